/* logic/hpc_pkg.sv */
// package of constants and types for the host port control pins
//
// Notes on behaviour
// - write data stored at write strobe rising edge
// - interrupt low while any unmasked event pending
// - interrupt released once no unmasked event is pending
// - global, framer, line and tester mask levels
// - select low parallel port, high serial port
// - select pin shows status when compat bit set
// - timing select high strobe plus direction, low split
// - host holds timing select low in serial mode
// - device reset low clears registers, sets every mask register to all ones
// - master clock rate from period and frequency bits
// - strobes ignored, bus undriven, without chip select
// - bus driven while read strobe and select low
package hpc_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_PORTS = 8;
  // device register addresses
  localparam logic [12:0] ADDR_GTCR = 13'h0000;
  localparam logic [12:0] ADDR_STATUS = 13'h0001;
  localparam logic [12:0] ADDR_GMASK = 13'h0002;
  localparam logic [12:0] ADDR_FR_MASK = 13'h0003;
  localparam logic [12:0] ADDR_LIU_MASK = 13'h0004;
  localparam logic [12:0] ADDR_BERT_MASK = 13'h0005;
  localparam logic [12:0] ADDR_FR_STAT = 13'h0006;
  localparam logic [12:0] ADDR_LIU_STAT = 13'h0007;
  localparam logic [12:0] ADDR_BERT_STAT = 13'h0008;
  localparam logic [12:0] ADDR_CLKSEL = 13'h0009;
  localparam logic [12:0] ADDR_SCRATCH = 13'h000A;
  // global control fields
  localparam int unsigned GTCR_COMPAT_BIT = 0;
  localparam int unsigned GTCR_STSEL_LSB = 1;
  localparam int unsigned CLK_PERIOD0_BIT = 0;
  localparam int unsigned CLK_PERIOD1_BIT = 1;
  localparam int unsigned CLK_FREQ_BIT = 2;
  // global mask bits
  localparam int unsigned GM_FR_BIT = 0;
  localparam int unsigned GM_LIU_BIT = 1;
  localparam int unsigned GM_BERT_BIT = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  // controller register offsets
  localparam logic [3:0] C_CMD = 4'h0;
  localparam logic [3:0] C_ADDR_LO = 4'h1;
  localparam logic [3:0] C_ADDR_HI = 4'h2;
  localparam logic [3:0] C_WDATA = 4'h3;
  localparam logic [3:0] C_RDATA = 4'h4;
  localparam logic [3:0] C_STAT = 4'h5;
  localparam logic [3:0] C_IRQ_STAT = 4'h6;
  localparam logic [3:0] C_IRQ_MASK = 4'h7;
  localparam logic [3:0] C_CFG = 4'h8;
  localparam int unsigned CMD_WR_BIT = 0;
  localparam int unsigned CMD_RD_BIT = 1;
  localparam int unsigned CFG_TIMING_BIT = 0;
  localparam int unsigned CFG_SPI_BIT = 1;
  localparam int unsigned CFG_RST_BIT = 2;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_DEV_BIT = 1;
  // bus phase lengths in clocks
  localparam logic [3:0] SETUP_CYC = 4'h2;
  localparam logic [3:0] STROBE_CYC = 4'h4;
  localparam logic [3:0] HOLD_CYC = 4'h2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [3:0] {
    HPC_IDLE = 4'b0001,
    HPC_SETUP = 4'b0010,
    HPC_STROBE = 4'b0100,
    HPC_HOLD = 4'b1000
  } hpc_state_e;
endpackage

/* logic/hpc_bus_if.sv */
// pin bundle between host controller and device port
`timescale 1ns/1ps
`default_nettype none
interface hpc_bus_if;
  logic [12:0] addr;
  logic [7:0] data_h2d;
  logic data_h2d_oe_n;
  logic [7:0] data_d2h;
  logic data_d2h_oe_n;
  logic chip_select_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic bus_timing_select;
  logic spi_sel_in;
  logic spi_sel_out;
  logic spi_sel_out_oe_n;
  logic interrupt_request_n;
  logic interrupt_request_oe_n;
  logic device_reset_n;
  modport device (
    input addr,
    input data_h2d,
    input data_h2d_oe_n,
    output data_d2h,
    output data_d2h_oe_n,
    input chip_select_n,
    input write_strobe_n,
    input read_strobe_n,
    input bus_timing_select,
    input spi_sel_in,
    output spi_sel_out,
    output spi_sel_out_oe_n,
    output interrupt_request_n,
    output interrupt_request_oe_n,
    input device_reset_n
  );
  modport host (
    output addr,
    output data_h2d,
    output data_h2d_oe_n,
    input data_d2h,
    input data_d2h_oe_n,
    output chip_select_n,
    output write_strobe_n,
    output read_strobe_n,
    output bus_timing_select,
    output spi_sel_in,
    input spi_sel_out,
    input spi_sel_out_oe_n,
    input interrupt_request_n,
    input interrupt_request_oe_n,
    output device_reset_n
  );
endinterface
`default_nettype wire

/* logic/hpc_device.sv */
// device end: parallel register port, masked interrupt, mode pins
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hpc_device (
  input wire logic clk,
  input wire logic rst,
  hpc_bus_if.device bus,
  input wire logic [7:0] fr_event,
  input wire logic [7:0] liu_event,
  input wire logic [7:0] bert_event,
  input wire logic [7:0] analog_loss_flag,
  input wire logic [7:0] rx_signaling_freeze_flag,
  input wire logic [7:0] framer_loss_flag,
  output logic spi_mode,
  output logic [2:0] master_clk_sel
);
  typedef struct packed {
    logic [1:0] wr_s;
    logic [1:0] rd_s;
    logic [1:0] cs_s;
    logic [1:0] tsel_s;
    logic [1:0] sel_s;
    logic [1:0] rstn_s;
    logic wr_q;
    logic [7:0] gtcr;
    logic [7:0] gmask;
    logic [7:0] fr_mask;
    logic [7:0] liu_mask;
    logic [7:0] bert_mask;
    logic [7:0] fr_stat;
    logic [7:0] liu_stat;
    logic [7:0] bert_stat;
    logic [7:0] clksel;
    logic [7:0] scratch;
    logic [7:0] rdata;
    logic rd_en;
    logic irq;
    logic sel_o;
  } hpc_dev_s;
  hpc_dev_s q;
  hpc_dev_s next_q;
  logic strobe_wr;
  logic strobe_rd;
  logic wr_rise;
  logic [7:0] stat_sel;

  function automatic logic [7:0] hpc_w1c(input logic [7:0] cur, input logic [7:0] ev,
                                          input logic [7:0] clr);
    hpc_w1c = (cur & ~clr) | ev;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // strobe decoding per timing style
  always_comb
  begin
    if (q.tsel_s[1])
    begin
      strobe_wr = ~q.rd_s[1] & ~q.wr_s[1];
      strobe_rd = ~q.rd_s[1] & q.wr_s[1];
    end
    else
    begin
      strobe_wr = ~q.wr_s[1];
      strobe_rd = ~q.rd_s[1];
    end
  end
  localparam int unsigned GTCR_SEL_HI = hpc_pkg::GTCR_STSEL_LSB + 1;
  assign wr_rise = q.wr_q & ~(strobe_wr & ~q.cs_s[1]);
  assign stat_sel = q.gtcr[GTCR_SEL_HI:hpc_pkg::GTCR_STSEL_LSB] == 2'h1 ?
                    rx_signaling_freeze_flag :
                    (q.gtcr[GTCR_SEL_HI:hpc_pkg::GTCR_STSEL_LSB] == 2'h2 ?
                     framer_loss_flag : analog_loss_flag);

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_q = q;
    next_q.wr_s = {q.wr_s[0], bus.write_strobe_n};
    next_q.rd_s = {q.rd_s[0], bus.read_strobe_n};
    next_q.cs_s = {q.cs_s[0], bus.chip_select_n};
    next_q.tsel_s = {q.tsel_s[0], bus.bus_timing_select};
    next_q.sel_s = {q.sel_s[0], bus.spi_sel_in};
    next_q.rstn_s = {q.rstn_s[0], bus.device_reset_n};
    next_q.wr_q = strobe_wr & ~q.cs_s[1] & ~q.sel_s[1];
    next_q.fr_stat = hpc_w1c(q.fr_stat, fr_event, 8'h00);
    next_q.liu_stat = hpc_w1c(q.liu_stat, liu_event, 8'h00);
    next_q.bert_stat = hpc_w1c(q.bert_stat, bert_event, 8'h00);
    if (wr_rise && !q.sel_s[1])
    begin
      if (bus.addr == hpc_pkg::ADDR_GTCR)
        next_q.gtcr = bus.data_h2d;
      else if (bus.addr == hpc_pkg::ADDR_GMASK)
        next_q.gmask = bus.data_h2d;
      else if (bus.addr == hpc_pkg::ADDR_FR_MASK)
        next_q.fr_mask = bus.data_h2d;
      else if (bus.addr == hpc_pkg::ADDR_LIU_MASK)
        next_q.liu_mask = bus.data_h2d;
      else if (bus.addr == hpc_pkg::ADDR_BERT_MASK)
        next_q.bert_mask = bus.data_h2d;
      else if (bus.addr == hpc_pkg::ADDR_FR_STAT)
        next_q.fr_stat = hpc_w1c(q.fr_stat, fr_event, bus.data_h2d);
      else if (bus.addr == hpc_pkg::ADDR_LIU_STAT)
        next_q.liu_stat = hpc_w1c(q.liu_stat, liu_event, bus.data_h2d);
      else if (bus.addr == hpc_pkg::ADDR_BERT_STAT)
        next_q.bert_stat = hpc_w1c(q.bert_stat, bert_event, bus.data_h2d);
      else if (bus.addr == hpc_pkg::ADDR_CLKSEL)
        next_q.clksel = bus.data_h2d;
      else if (bus.addr == hpc_pkg::ADDR_SCRATCH)
        next_q.scratch = bus.data_h2d;
    end
    next_q.rd_en = strobe_rd & ~q.cs_s[1] & ~q.sel_s[1];
    if (bus.addr == hpc_pkg::ADDR_GTCR)
      next_q.rdata = q.gtcr;
    else if (bus.addr == hpc_pkg::ADDR_STATUS)
      next_q.rdata = {5'h00, |q.bert_stat, |q.liu_stat, |q.fr_stat};
    else if (bus.addr == hpc_pkg::ADDR_GMASK)
      next_q.rdata = q.gmask;
    else if (bus.addr == hpc_pkg::ADDR_FR_MASK)
      next_q.rdata = q.fr_mask;
    else if (bus.addr == hpc_pkg::ADDR_LIU_MASK)
      next_q.rdata = q.liu_mask;
    else if (bus.addr == hpc_pkg::ADDR_BERT_MASK)
      next_q.rdata = q.bert_mask;
    else if (bus.addr == hpc_pkg::ADDR_FR_STAT)
      next_q.rdata = q.fr_stat;
    else if (bus.addr == hpc_pkg::ADDR_LIU_STAT)
      next_q.rdata = q.liu_stat;
    else if (bus.addr == hpc_pkg::ADDR_BERT_STAT)
      next_q.rdata = q.bert_stat;
    else if (bus.addr == hpc_pkg::ADDR_CLKSEL)
      next_q.rdata = q.clksel;
    else if (bus.addr == hpc_pkg::ADDR_SCRATCH)
      next_q.rdata = q.scratch;
    else
      next_q.rdata = hpc_pkg::RST_BYTE;
    // three mask levels under one global level
    next_q.irq = (|(q.fr_stat & ~q.fr_mask) & ~q.gmask[hpc_pkg::GM_FR_BIT]) |
                 (|(q.liu_stat & ~q.liu_mask) & ~q.gmask[hpc_pkg::GM_LIU_BIT]) |
                 (|(q.bert_stat & ~q.bert_mask) & ~q.gmask[hpc_pkg::GM_BERT_BIT]);
    next_q.sel_o = |stat_sel;
    if (!q.rstn_s[1])
    begin
      next_q = '0;
      next_q.wr_s = q.wr_s;
      next_q.rd_s = q.rd_s;
      next_q.cs_s = {q.cs_s[0], bus.chip_select_n};
      next_q.tsel_s = q.tsel_s;
      next_q.sel_s = q.sel_s;
      next_q.rstn_s = {q.rstn_s[0], bus.device_reset_n};
      next_q.gmask = hpc_pkg::MASK_RST;
      next_q.fr_mask = hpc_pkg::MASK_RST;
      next_q.liu_mask = hpc_pkg::MASK_RST;
      next_q.bert_mask = hpc_pkg::MASK_RST;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.wr_s <= 2'h3;
      q.rd_s <= 2'h3;
      q.cs_s <= 2'h3;
      q.gmask <= hpc_pkg::MASK_RST;
      q.fr_mask <= hpc_pkg::MASK_RST;
      q.liu_mask <= hpc_pkg::MASK_RST;
      q.bert_mask <= hpc_pkg::MASK_RST;
    end
    else
      q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////
  assign bus.data_d2h = q.rdata;
  assign bus.data_d2h_oe_n = ~(q.rd_en & ~q.cs_s[1]);
  assign bus.interrupt_request_n = 1'b0;
  assign bus.interrupt_request_oe_n = ~q.irq;
  assign bus.spi_sel_out = q.sel_o;
  assign bus.spi_sel_out_oe_n = ~q.gtcr[hpc_pkg::GTCR_COMPAT_BIT];
  assign spi_mode = q.sel_s[1] & ~q.gtcr[hpc_pkg::GTCR_COMPAT_BIT];
  assign master_clk_sel = {q.clksel[hpc_pkg::CLK_FREQ_BIT],
                           q.clksel[hpc_pkg::CLK_PERIOD1_BIT],
                           q.clksel[hpc_pkg::CLK_PERIOD0_BIT]};
endmodule
`default_nettype wire

/* logic/hpc_host.sv */
// host end: drives parallel port cycles from a software register port
`timescale 1ns/1ps
`default_nettype none
module hpc_host (
  input wire logic clk,
  input wire logic rst,
  hpc_bus_if.host bus,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq
);
  typedef struct packed {
    hpc_pkg::hpc_state_e st;
    logic [3:0] cnt;
    logic is_wr;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] cfg;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] intr_s;
    logic [7:0] sw_rdata;
  } hpc_host_s;
  hpc_host_s q;
  hpc_host_s next_q;
  logic dev_irq;
  logic busy;
  logic done;

  assign busy = q.st != hpc_pkg::HPC_IDLE;
  assign done = q.st == hpc_pkg::HPC_HOLD && q.cnt == hpc_pkg::CNT_ONE;
  assign dev_irq = ~q.intr_s[1];

  always_comb
  begin
    next_q = q;
    next_q.intr_s = {q.intr_s[0], bus.interrupt_request_n | bus.interrupt_request_oe_n};
    if (q.cnt != hpc_pkg::CNT_ZERO)
      next_q.cnt = q.cnt - hpc_pkg::CNT_ONE;
    case (q.st)
      hpc_pkg::HPC_IDLE:
      begin
        if (sw_wr && sw_addr == hpc_pkg::C_CMD &&
            (sw_wdata[hpc_pkg::CMD_WR_BIT] || sw_wdata[hpc_pkg::CMD_RD_BIT]))
        begin
          next_q.is_wr = sw_wdata[hpc_pkg::CMD_WR_BIT];
          next_q.st = hpc_pkg::HPC_SETUP;
          next_q.cnt = hpc_pkg::SETUP_CYC;
        end
      end
      hpc_pkg::HPC_SETUP:
        if (q.cnt == hpc_pkg::CNT_ONE)
        begin
          next_q.st = hpc_pkg::HPC_STROBE;
          next_q.cnt = hpc_pkg::STROBE_CYC;
        end
      hpc_pkg::HPC_STROBE:
        if (q.cnt == hpc_pkg::CNT_ONE)
        begin
          if (!q.is_wr)
            next_q.rdata = bus.data_d2h;
          next_q.st = hpc_pkg::HPC_HOLD;
          next_q.cnt = hpc_pkg::HOLD_CYC;
        end
      hpc_pkg::HPC_HOLD:
        if (q.cnt == hpc_pkg::CNT_ONE)
          next_q.st = hpc_pkg::HPC_IDLE;
      default:
        next_q.st = hpc_pkg::HPC_IDLE;
    endcase
    if (sw_wr && !busy)
    begin
      if (sw_addr == hpc_pkg::C_ADDR_LO)
        next_q.addr[7:0] = sw_wdata;
      else if (sw_addr == hpc_pkg::C_ADDR_HI)
        next_q.addr[12:8] = sw_wdata[4:0];
      else if (sw_addr == hpc_pkg::C_WDATA)
        next_q.wdata = sw_wdata;
      else if (sw_addr == hpc_pkg::C_CFG)
        next_q.cfg = sw_wdata;
    end
    if (sw_wr && sw_addr == hpc_pkg::C_IRQ_MASK)
      next_q.irq_mask = sw_wdata[1:0];
    if (sw_wr && sw_addr == hpc_pkg::C_IRQ_STAT)
      next_q.irq_stat = q.irq_stat & ~sw_wdata[1:0];
    // set wins over clear
    next_q.irq_stat[hpc_pkg::IRQ_DONE_BIT] = next_q.irq_stat[hpc_pkg::IRQ_DONE_BIT] | done;
    next_q.irq_stat[hpc_pkg::IRQ_DEV_BIT] = next_q.irq_stat[hpc_pkg::IRQ_DEV_BIT] | dev_irq;
    next_q.sw_rdata = hpc_pkg::RST_BYTE;
    if (sw_rd)
    begin
      if (sw_addr == hpc_pkg::C_ADDR_LO)
        next_q.sw_rdata = q.addr[7:0];
      else if (sw_addr == hpc_pkg::C_ADDR_HI)
        next_q.sw_rdata = {3'h0, q.addr[12:8]};
      else if (sw_addr == hpc_pkg::C_WDATA)
        next_q.sw_rdata = q.wdata;
      else if (sw_addr == hpc_pkg::C_RDATA)
        next_q.sw_rdata = q.rdata;
      else if (sw_addr == hpc_pkg::C_STAT)
        next_q.sw_rdata = {6'h00, dev_irq, busy};
      else if (sw_addr == hpc_pkg::C_IRQ_STAT)
        next_q.sw_rdata = {6'h00, q.irq_stat};
      else if (sw_addr == hpc_pkg::C_IRQ_MASK)
        next_q.sw_rdata = {6'h00, q.irq_mask};
      else if (sw_addr == hpc_pkg::C_CFG)
        next_q.sw_rdata = q.cfg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= hpc_pkg::HPC_IDLE;
      q.intr_s <= 2'h3;
    end
    else
      q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////
  logic strobing;
  logic cyc;
  logic timing_sel;
  assign strobing = q.st == hpc_pkg::HPC_STROBE;
  assign cyc = busy;
  // serial mode forces split strobe timing
  assign timing_sel = q.cfg[hpc_pkg::CFG_TIMING_BIT] & ~q.cfg[hpc_pkg::CFG_SPI_BIT];
  assign bus.addr = q.addr;
  assign bus.data_h2d = q.wdata;
  assign bus.data_h2d_oe_n = ~(cyc & q.is_wr);
  assign bus.chip_select_n = ~cyc;
  assign bus.write_strobe_n = timing_sel ? ~(cyc & q.is_wr) : ~(strobing & q.is_wr);
  assign bus.read_strobe_n = timing_sel ? ~strobing : ~(strobing & ~q.is_wr);
  assign bus.bus_timing_select = timing_sel;
  assign bus.spi_sel_in = q.cfg[hpc_pkg::CFG_SPI_BIT];
  assign bus.device_reset_n = ~q.cfg[hpc_pkg::CFG_RST_BIT];
  assign sw_rdata = q.sw_rdata;
  assign irq = |(q.irq_stat & q.irq_mask);
endmodule
`default_nettype wire

/* test/hpc_check_sva.sv */
// assertions on the pins between host and device ends
`timescale 1ns/1ps
`default_nettype none
module hpc_check (
  input wire logic clk,
  input wire logic rst,
  input wire logic [12:0] addr,
  input wire logic data_h2d_oe_n,
  input wire logic data_d2h_oe_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic bus_timing_select,
  input wire logic spi_sel_in,
  input wire logic interrupt_request_n,
  input wire logic interrupt_request_oe_n,
  input wire logic device_reset_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_cs_span;
    $fell(chip_select_n) |-> (!chip_select_n)[*8] ##1 chip_select_n;
  endproperty
  a_cs_span: assert property (p_cs_span) else $error("select span wrong");
  property p_wr_len;
    $fell(write_strobe_n) && !bus_timing_select |-> (!write_strobe_n)[*4] ##1 write_strobe_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
  property p_wr_drive;
    !write_strobe_n && !bus_timing_select |-> !data_h2d_oe_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
  property p_addr_hold;
    !chip_select_n && !$fell(chip_select_n) |-> $stable(addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
  property p_rd_in_cs;
    !read_strobe_n |-> !chip_select_n;
  endproperty
  a_rd_in_cs: assert property (p_rd_in_cs) else $error("strobe outside select");
  property p_bus_quiet;
    chip_select_n[*4] |-> data_d2h_oe_n;
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("data driven unselected");
  property p_rd_drive;
    $fell(read_strobe_n) && !bus_timing_select && !spi_sel_in && device_reset_n
      |-> ##[1:4] !data_d2h_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  property p_split_excl;
    !bus_timing_select |-> read_strobe_n || write_strobe_n;
  endproperty
  a_split_excl: assert property (p_split_excl) else $error("both strobes low");
  property p_serial_bts;
    spi_sel_in |-> !bus_timing_select;
  endproperty
  a_serial_bts: assert property (p_serial_bts) else $error("timing select high in serial");
  property p_spi_quiet;
    spi_sel_in[*4] |-> data_d2h_oe_n;
  endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("parallel data in serial mode");
  property p_irq_od;
    !interrupt_request_oe_n |-> !interrupt_request_n;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("interrupt not pulled low");
  property p_dev_reset;
    (!device_reset_n)[*4] |-> interrupt_request_oe_n && data_d2h_oe_n;
  endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("outputs active in reset");
  c_read: cover property ($fell(read_strobe_n) && !bus_timing_select);
  c_irq: cover property ($fell(interrupt_request_oe_n));
  c_reset: cover property ($fell(device_reset_n));
endmodule
`default_nettype wire

/* test/host_port_control_pins_tb.sv */
// self-checking bench for host and device ends joined pin to pin
`timescale 1ns/1ps
`default_nettype none
module host_port_control_pins_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic irq;
  logic [7:0] fr_event = 8'h00;
  logic [7:0] liu_event = 8'h00;
  logic [7:0] bert_event = 8'h00;
  logic spi_mode;
  logic [2:0] master_clk_sel;
  logic [7:0] rd;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  hpc_bus_if bus ();
  hpc_host hpc_host_i (.clk(clk), .rst(rst), .bus(bus), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  hpc_device hpc_device_i (.clk(clk), .rst(rst), .bus(bus), .fr_event(fr_event),
    .liu_event(liu_event), .bert_event(bert_event), .analog_loss_flag(8'h01),
    .rx_signaling_freeze_flag(8'h00), .framer_loss_flag(8'h80), .spi_mode(spi_mode),
    .master_clk_sel(master_clk_sel));
  hpc_check hpc_check_i (.clk(clk), .rst(rst), .addr(bus.addr), .data_h2d_oe_n(bus.data_h2d_oe_n),
    .data_d2h_oe_n(bus.data_d2h_oe_n), .chip_select_n(bus.chip_select_n),
    .write_strobe_n(bus.write_strobe_n), .read_strobe_n(bus.read_strobe_n),
    .bus_timing_select(bus.bus_timing_select), .spi_sel_in(bus.spi_sel_in),
    .interrupt_request_n(bus.interrupt_request_n),
    .interrupt_request_oe_n(bus.interrupt_request_oe_n), .device_reset_n(bus.device_reset_n));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    rd = sw_rdata;
  endtask
  // one device access, waits for busy to drop, leaves read byte in rd
  task automatic dev(input logic wr, input logic [12:0] a, input logic [7:0] d);
    sw_w(hpc_pkg::C_ADDR_LO, a[7:0]);
    sw_w(hpc_pkg::C_ADDR_HI, {3'h0, a[12:8]});
    sw_w(hpc_pkg::C_WDATA, d);
    sw_w(hpc_pkg::C_CMD, wr ? 8'h01 : 8'h02);
    // a hung cycle is caught by the cycle ceiling
    do
    begin
      sw_r(hpc_pkg::C_STAT);
    end
    while (rd[0] !== 1'b0);
    sw_r(hpc_pkg::C_RDATA);
  endtask
  task automatic ev(input int g, input logic [7:0] v);
    @(posedge clk);
    fr_event <= (g == 0) ? v : 8'h00;
    liu_event <= (g == 1) ? v : 8'h00;
    bert_event <= (g == 2) ? v : 8'h00;
    @(posedge clk);
    fr_event <= 8'h00;
    liu_event <= 8'h00;
    bert_event <= 8'h00;
    repeat (6) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_styles();
    dev(1'b0, hpc_pkg::ADDR_GMASK, 8'h00);
    chk(rd, hpc_pkg::MASK_RST);
    for (int s = 0; s < 2; s++)
    begin
      sw_w(hpc_pkg::C_CFG, s[7:0]);
      dev(1'b1, hpc_pkg::ADDR_SCRATCH, 8'hA5 ^ s[7:0]);
      dev(1'b0, hpc_pkg::ADDR_SCRATCH, 8'h00);
      chk(rd, 8'hA5 ^ s[7:0]);
    end
    sw_w(hpc_pkg::C_CFG, 8'h00);
    dev(1'b0, 13'h1FFF, 8'h00);
    chk(rd, 8'h00);
  endtask
  task automatic t_irq();
    sw_w(hpc_pkg::C_IRQ_MASK, 8'h01);
    for (int g = 0; g < 3; g++)
    begin
      dev(1'b1, hpc_pkg::ADDR_GMASK, ~(8'h01 << g));
      dev(1'b1, hpc_pkg::ADDR_FR_MASK + 13'(g), 8'hFE);
      ev(g, 8'h02);
      sw_r(hpc_pkg::C_STAT);
      chk(rd & 8'h02, 8'h00);
      ev(g, 8'h01);
      sw_r(hpc_pkg::C_STAT);
      chk(rd & 8'h02, 8'h02);
      dev(1'b1, hpc_pkg::ADDR_FR_STAT + 13'(g), 8'hFF);
      sw_w(hpc_pkg::C_IRQ_STAT, 8'h02);
      sw_r(hpc_pkg::C_STAT);
      chk(rd & 8'h02, 8'h00);
    end
    // host mask bit high enables that status bit
    dev(1'b1, hpc_pkg::ADDR_GMASK, 8'h06);
    sw_w(hpc_pkg::C_IRQ_MASK, 8'h02);
    sw_w(hpc_pkg::C_IRQ_STAT, 8'h03);
    #1;
    chk({7'h00, irq}, 8'h00);
    ev(0, 8'h01);
    #1;
    chk({7'h00, irq}, 8'h01);
    sw_w(hpc_pkg::C_IRQ_MASK, 8'h00);
    #1;
    chk({7'h00, irq}, 8'h00);
    sw_w(hpc_pkg::C_IRQ_MASK, 8'h02);
    dev(1'b1, hpc_pkg::ADDR_FR_STAT, 8'hFF);
    sw_w(hpc_pkg::C_IRQ_STAT, 8'h03);
    #1;
    chk({7'h00, irq}, 8'h00);
    dev(1'b1, hpc_pkg::ADDR_GMASK, 8'h07);
    ev(0, 8'h01);
    sw_r(hpc_pkg::C_STAT);
    chk(rd & 8'h02, 8'h00);
    sw_r(hpc_pkg::C_IRQ_STAT);
    chk(rd, 8'h01);
  endtask
  task automatic t_reset_pin();
    dev(1'b1, hpc_pkg::ADDR_SCRATCH, 8'h3C);
    sw_w(hpc_pkg::C_CFG, 8'h04);
    repeat (4) @(posedge clk);
    sw_w(hpc_pkg::C_CFG, 8'h00);
    repeat (4) @(posedge clk);
    dev(1'b0, hpc_pkg::ADDR_SCRATCH, 8'h00);
    chk(rd, hpc_pkg::RST_BYTE);
    dev(1'b0, hpc_pkg::ADDR_GMASK, 8'h00);
    chk(rd, hpc_pkg::MASK_RST);
  endtask
  task automatic t_spi();
    sw_w(hpc_pkg::C_CFG, 8'h02);
    repeat (4) @(posedge clk);
    chk({7'h00, spi_mode}, 8'h01);
    dev(1'b1, hpc_pkg::ADDR_SCRATCH, 8'h77);
    sw_w(hpc_pkg::C_CFG, 8'h00);
    repeat (4) @(posedge clk);
    chk({7'h00, spi_mode}, 8'h00);
    dev(1'b0, hpc_pkg::ADDR_SCRATCH, 8'h00);
    chk(rd, 8'h00);
  endtask
  task automatic t_compat();
    // status select 1 freeze (all low), 2 framer loss, 0 analog loss
    dev(1'b1, hpc_pkg::ADDR_GTCR, 8'h03);
    chk({7'h00, bus.spi_sel_out}, 8'h00);
    dev(1'b1, hpc_pkg::ADDR_GTCR, 8'h05);
    chk({7'h00, bus.spi_sel_out}, 8'h01);
    dev(1'b1, hpc_pkg::ADDR_GTCR, 8'h01);
    chk({7'h00, bus.spi_sel_out}, 8'h01);
    sw_w(hpc_pkg::C_CFG, 8'h02);
    repeat (4) @(posedge clk);
    chk({7'h00, spi_mode}, 8'h00);
    chk({7'h00, bus.spi_sel_out_oe_n}, 8'h00);
    sw_w(hpc_pkg::C_CFG, 8'h00);
    repeat (4) @(posedge clk);
    dev(1'b1, hpc_pkg::ADDR_GTCR, 8'h00);
    chk({7'h00, bus.spi_sel_out_oe_n}, 8'h01);
  endtask
  task automatic t_clk();
    for (int v = 0; v < 8; v++)
    begin
      dev(1'b1, hpc_pkg::ADDR_CLKSEL, v[7:0]);
      chk({5'h00, master_clk_sel}, v[7:0]);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_styles();
    t_irq();
    t_reset_pin();
    t_spi();
    t_compat();
    t_clk();
    test_done();
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
endmodule
`default_nettype wire
